/* src/fbu_consts.vh */
`ifndef FBU_CONSTS_VH
`define FBU_CONSTS_VH
// ---------------------------------------------
// register byte offsets
// ---------------------------------------------
`define FBU_OFS_DATA     5'h00
`define FBU_OFS_CTRL     5'h04
`define FBU_OFS_DIV      5'h08
`define FBU_OFS_STAT     5'h0C
`define FBU_OFS_IST      5'h10
`define FBU_OFS_IMSK     5'h14
`define FBU_OFS_PMUX     5'h18
// ---------------------------------------------
// control register fields
// ---------------------------------------------
`define FBU_CTL_CLK_HI   1
`define FBU_CTL_CLK_LO   0
`define FBU_CTL_SEVEN    2
`define FBU_CTL_PEN      3
`define FBU_CTL_PTY_HI   5
`define FBU_CTL_PTY_LO   4
`define FBU_CTL_TWOSTOP  6
`define FBU_CTL_RST      7'h00
`define FBU_PTY_ODD      2'h0
`define FBU_PTY_EVEN     2'h1
`define FBU_PTY_MARK     2'h2
`define FBU_PTY_SPACE    2'h3
// ---------------------------------------------
// divider, clocks, pin mux
// ---------------------------------------------
`define FBU_DIV_RST      16'h0080
`define FBU_DIV_MIN      16'h0040
`define FBU_FRAC_ONE     17'h00008
`define FBU_CORE_KHZ     50000
`define FBU_UCLK_KHZ     10000
`define FBU_MUX_UART     3'h3
`define FBU_PMUX_RST     21'h000000
// ---------------------------------------------
// interrupt status bits
// ---------------------------------------------
`define FBU_IRQ_PAR      0
`define FBU_IRQ_FRM      1
`define FBU_IRQ_OVR      2
`define FBU_IRQ_RXC      3
`define FBU_IRQ_TXE      4
`define FBU_IRQ_W        5
`endif

/* src/fbu_uart.v */
// How it works
// - each of four receive pins and three transmit pins joins the serial unit when its mux field holds 3.
// - software picks the unit clock of 10, 5, 2.5 or 1.25 MHz from the core clock.
// - the divider register holds a 13-bit integer part above a 3-bit fraction.
// - each bit lasts that fractional divider in unit clock periods, at least 8 of them.
// - characters carry seven or eight data bits as configured.
// - parity is off, or odd, even, mark or space.
// - frames end in one or two stop bits, in both directions.
// - receive and transmit each have a four-entry, eight-bit FIFO.
// - the status register shows how many received characters wait.
// - reception errors set sticky status bits that can raise the interrupt.
// - the unit drives the transmit line and samples the receive line.
//
// Local design decisions: the register offsets and the strobed register port.
`timescale 1ns/1ps
`include "fbu_consts.vh"
module fbu_uart #(
	parameter DEPTH = 4
) (
	input  wire        core_clk_i,
	input  wire        sys_rst_i,
	input  wire [4:0]  addr_i,
	input  wire [31:0] wdata_i,
	input  wire        wr_i,
	input  wire        rd_i,
	output reg  [31:0] rdata_o,
	input  wire [3:0]  rx_pin_i,
	output reg  [2:0]  tx_pin_o,
	output reg  [2:0]  tx_oe_o,
	output reg         irq_o
);
	// ---------------------------------------------
	// states and helpers
	// ---------------------------------------------
	localparam S_IDLE  = 5'h01;
	localparam S_START = 5'h02;
	localparam S_DATA  = 5'h04;
	localparam S_PAR   = 5'h08;
	localparam S_STOP  = 5'h10;
	localparam [31:0] PRE_RATIO = (`FBU_CORE_KHZ / `FBU_UCLK_KHZ);
	localparam [5:0]  PRE_BASE  = PRE_RATIO[5:0];

	// one unit clock step of a bit timer, in eighths of a unit clock
	function [17:0] frac_step;
		input [16:0] acc;
		input [15:0] dv;
		reg   [16:0] s;
		begin
			s = acc + `FBU_FRAC_ONE;
			if (s >= {1'b0, dv}) begin
				frac_step = {1'b1, s - {1'b0, dv}};
			end else begin
				frac_step = {1'b0, s};
			end
		end
	endfunction

	// parity bit for a character
	function par_bit;
		input [7:0] d;
		input [1:0] ty;
		begin
			case (ty)
				`FBU_PTY_ODD:  par_bit = ~^d;
				`FBU_PTY_EVEN: par_bit = ^d;
				`FBU_PTY_MARK: par_bit = 1'b1;
				default:       par_bit = 1'b0;
			endcase
		end
	endfunction

	// ---------------------------------------------
	// registers
	// ---------------------------------------------
	reg [6:0]              ctrl_ff;
	reg [15:0]             div_ff;
	reg [`FBU_IRQ_W-1:0]   ist_ff;
	reg [`FBU_IRQ_W-1:0]   imsk_ff;
	reg [20:0]             pmux_ff;
	reg [5:0]              pre_ff;
	reg                    utick_ff;
	reg [7:0]              rxm_ff [0:DEPTH-1];
	reg [7:0]              txm_ff [0:DEPTH-1];
	reg [1:0]              rxw_ff;
	reg [1:0]              rxr_ff;
	reg [2:0]              rxc_ff;
	reg [1:0]              txw_ff;
	reg [1:0]              txr_ff;
	reg [2:0]              txc_ff;
	reg [4:0]              tst_ff;
	reg [16:0]             tacc_ff;
	reg [7:0]              tsh_ff;
	reg                    tpar_ff;
	reg [2:0]              tcnt_ff;
	reg                    tline_ff;
	reg [4:0]              rst_ff;
	reg [16:0]             racc_ff;
	reg [7:0]              rsh_ff;
	reg [2:0]              rcnt_ff;
	reg                    rline_ff;
	reg                    perr_ff;
	reg                    ferr_ff;
	reg [`FBU_IRQ_W-1:0]   nxt_ist;
	reg [31:0]             nxt_rdata;
	reg                    nxt_rx;
	integer                i;
	integer                j;

	// ---------------------------------------------
	// configuration decode
	// ---------------------------------------------
	wire [1:0]  clk_sel  = ctrl_ff[`FBU_CTL_CLK_HI:`FBU_CTL_CLK_LO];
	wire        seven    = ctrl_ff[`FBU_CTL_SEVEN];
	wire        pen      = ctrl_ff[`FBU_CTL_PEN];
	wire [1:0]  pty      = ctrl_ff[`FBU_CTL_PTY_HI:`FBU_CTL_PTY_LO];
	wire        two_stop = ctrl_ff[`FBU_CTL_TWOSTOP];
	wire [2:0]  last_bit = seven ? 3'h6 : 3'h7;
	wire [5:0]  pre_lim  = (PRE_BASE << clk_sel) - 6'h01;
	wire [15:0] eff_div  = (div_ff < `FBU_DIV_MIN) ? `FBU_DIV_MIN : div_ff;
	wire [17:0] tstep    = frac_step(tacc_ff, eff_div);
	wire [17:0] rstep    = frac_step(racc_ff, eff_div);
	wire        tdone    = utick_ff & tstep[17];
	wire        rdone    = utick_ff & rstep[17];
	wire [7:0]  rdata    = seven ? {1'b0, rsh_ff[7:1]} : rsh_ff;

	// ---------------------------------------------
	// fifo handshakes
	// ---------------------------------------------
	wire rd_data  = rd_i & (addr_i == `FBU_OFS_DATA);
	wire wr_data  = wr_i & (addr_i == `FBU_OFS_DATA);
	wire rx_pop   = rd_data & (rxc_ff != 3'h0);
	wire tx_push  = wr_data & (txc_ff != DEPTH[2:0]);
	wire tx_pop   = utick_ff & (tst_ff == S_IDLE) & (txc_ff != 3'h0);
	wire rx_fin   = rdone & (rst_ff == S_STOP) & ~(two_stop & (rcnt_ff == 3'h0));
	wire rx_push  = rx_fin & (rxc_ff != DEPTH[2:0]);
	wire rx_ovr   = rx_fin & (rxc_ff == DEPTH[2:0]);
	wire stop_low = rdone & (rst_ff == S_STOP) & ~rline_ff;
	wire par_bad  = rdone & (rst_ff == S_PAR) & (rline_ff != par_bit(rdata, pty));

	// ---------------------------------------------
	// receive pin select and next interrupt status
	// ---------------------------------------------
	always @* begin
		nxt_rx = 1'b1;
		for (i = 0; i < 4; i = i + 1) begin
			if (pmux_ff[i*3 +: 3] == `FBU_MUX_UART) begin
				nxt_rx = nxt_rx & rx_pin_i[i];
			end
		end
		nxt_ist = ist_ff;
		if (wr_i && (addr_i == `FBU_OFS_IST)) begin
			nxt_ist = ist_ff & ~wdata_i[`FBU_IRQ_W-1:0];
		end
		// set wins over a same-cycle clear
		nxt_ist[`FBU_IRQ_PAR] = nxt_ist[`FBU_IRQ_PAR] | par_bad;
		nxt_ist[`FBU_IRQ_FRM] = nxt_ist[`FBU_IRQ_FRM] | stop_low;
		nxt_ist[`FBU_IRQ_OVR] = nxt_ist[`FBU_IRQ_OVR] | rx_ovr;
		nxt_ist[`FBU_IRQ_RXC] = nxt_ist[`FBU_IRQ_RXC] | rx_push;
		nxt_ist[`FBU_IRQ_TXE] = nxt_ist[`FBU_IRQ_TXE] | (tx_pop & (txc_ff == 3'h1));
	end

	// ---------------------------------------------
	// read data mux
	// ---------------------------------------------
	always @* begin
		nxt_rdata = 32'h00000000;
		if (addr_i == `FBU_OFS_DATA) begin
			nxt_rdata[7:0] = (rxc_ff != 3'h0) ? rxm_ff[rxr_ff] : 8'h00;
		end else if (addr_i == `FBU_OFS_CTRL) begin
			nxt_rdata[6:0] = ctrl_ff;
		end else if (addr_i == `FBU_OFS_DIV) begin
			nxt_rdata[15:0] = div_ff;
		end else if (addr_i == `FBU_OFS_STAT) begin
			nxt_rdata[8:0] = {~rst_ff[0], ~tst_ff[0], perr_ff | ferr_ff, txc_ff, rxc_ff};
		end else if (addr_i == `FBU_OFS_IST) begin
			nxt_rdata[`FBU_IRQ_W-1:0] = ist_ff;
		end else if (addr_i == `FBU_OFS_IMSK) begin
			nxt_rdata[`FBU_IRQ_W-1:0] = imsk_ff;
		end else if (addr_i == `FBU_OFS_PMUX) begin
			nxt_rdata[20:0] = pmux_ff;
		end
	end

	// ---------------------------------------------
	// bus registers, unit clock, interrupt, pins
	// ---------------------------------------------
	always @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			ctrl_ff  <= `FBU_CTL_RST;
			div_ff   <= `FBU_DIV_RST;
			ist_ff   <= {`FBU_IRQ_W{1'b0}};
			imsk_ff  <= {`FBU_IRQ_W{1'b0}};
			pmux_ff  <= `FBU_PMUX_RST;
			pre_ff   <= 6'h00;
			utick_ff <= 1'b0;
			rdata_o  <= 32'h00000000;
			irq_o    <= 1'b0;
			tx_pin_o <= 3'h7;
			tx_oe_o  <= 3'h0;
			rline_ff <= 1'b1;
		end else begin
			if (wr_i && (addr_i == `FBU_OFS_CTRL)) begin
				ctrl_ff <= wdata_i[6:0];
			end else if (wr_i && (addr_i == `FBU_OFS_DIV)) begin
				div_ff <= wdata_i[15:0];
			end else if (wr_i && (addr_i == `FBU_OFS_IMSK)) begin
				imsk_ff <= wdata_i[`FBU_IRQ_W-1:0];
			end else if (wr_i && (addr_i == `FBU_OFS_PMUX)) begin
				pmux_ff <= wdata_i[20:0];
			end
			// unit clock enable from the core clock
			utick_ff <= (pre_ff >= pre_lim);
			pre_ff   <= (pre_ff >= pre_lim) ? 6'h00 : pre_ff + 6'h01;
			ist_ff   <= nxt_ist;
			irq_o    <= |(nxt_ist & imsk_ff);
			rdata_o  <= rd_i ? nxt_rdata : 32'h00000000;
			rline_ff <= nxt_rx;
			// transmit pins driven only when muxed to the serial unit
			for (j = 0; j < 3; j = j + 1) begin
				tx_oe_o[j]  <= (pmux_ff[12+j*3 +: 3] == `FBU_MUX_UART);
				tx_pin_o[j] <= (pmux_ff[12+j*3 +: 3] == `FBU_MUX_UART) ? tline_ff : 1'b1;
			end
		end
	end

	// ---------------------------------------------
	// fifos
	// ---------------------------------------------
	always @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			rxw_ff <= 2'h0;
			rxr_ff <= 2'h0;
			rxc_ff <= 3'h0;
			txw_ff <= 2'h0;
			txr_ff <= 2'h0;
			txc_ff <= 3'h0;
		end else begin
			if (rx_push) begin
				rxm_ff[rxw_ff] <= rdata;
				rxw_ff         <= rxw_ff + 2'h1;
			end
			if (rx_pop) begin
				rxr_ff <= rxr_ff + 2'h1;
			end
			rxc_ff <= rxc_ff + {2'h0, rx_push} - {2'h0, rx_pop};
			if (tx_push) begin
				txm_ff[txw_ff] <= wdata_i[7:0];
				txw_ff         <= txw_ff + 2'h1;
			end
			if (tx_pop) begin
				txr_ff <= txr_ff + 2'h1;
			end
			txc_ff <= txc_ff + {2'h0, tx_push} - {2'h0, tx_pop};
		end
	end

	// ---------------------------------------------
	// transmitter
	// ---------------------------------------------
	always @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			tst_ff   <= S_IDLE;
			tacc_ff  <= 17'h00000;
			tsh_ff   <= 8'h00;
			tpar_ff  <= 1'b0;
			tcnt_ff  <= 3'h0;
			tline_ff <= 1'b1;
		end else begin
			if (utick_ff && (tst_ff != S_IDLE)) begin
				tacc_ff <= tstep[16:0];
			end
			case (tst_ff)
				S_IDLE: begin
					if (tx_pop) begin
						tsh_ff   <= txm_ff[txr_ff];
						tpar_ff  <= par_bit(seven ? {1'b0, txm_ff[txr_ff][6:0]} : txm_ff[txr_ff], pty);
						tline_ff <= 1'b0;
						tacc_ff  <= 17'h00000;
						tst_ff   <= S_START;
					end
				end
				S_START: begin
					if (tdone) begin
						tline_ff <= tsh_ff[0];
						tsh_ff   <= {1'b0, tsh_ff[7:1]};
						tcnt_ff  <= 3'h0;
						tst_ff   <= S_DATA;
					end
				end
				S_DATA: begin
					if (tdone) begin
						if (tcnt_ff == last_bit) begin
							tline_ff <= pen ? tpar_ff : 1'b1;
							tcnt_ff  <= 3'h0;
							tst_ff   <= pen ? S_PAR : S_STOP;
						end else begin
							tline_ff <= tsh_ff[0];
							tsh_ff   <= {1'b0, tsh_ff[7:1]};
							tcnt_ff  <= tcnt_ff + 3'h1;
						end
					end
				end
				S_PAR: begin
					if (tdone) begin
						tline_ff <= 1'b1;
						tst_ff   <= S_STOP;
					end
				end
				S_STOP: begin
					if (tdone) begin
						if (two_stop && (tcnt_ff == 3'h0)) begin
							tcnt_ff <= 3'h1;
						end else begin
							tst_ff <= S_IDLE;
						end
					end
				end
				default: tst_ff <= S_IDLE;
			endcase
		end
	end

	// ---------------------------------------------
	// receiver
	// ---------------------------------------------
	always @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			rst_ff  <= S_IDLE;
			racc_ff <= 17'h00000;
			rsh_ff  <= 8'h00;
			rcnt_ff <= 3'h0;
			perr_ff <= 1'b0;
			ferr_ff <= 1'b0;
		end else begin
			if (utick_ff && (rst_ff != S_IDLE)) begin
				racc_ff <= rstep[16:0];
			end
			case (rst_ff)
				S_IDLE: begin
					if (!rline_ff) begin
						racc_ff <= {2'h0, eff_div[15:1]};                           // mid-bit sampling
						perr_ff <= 1'b0;
						ferr_ff <= 1'b0;
						rst_ff  <= S_START;
					end
				end
				S_START: begin
					if (rdone) begin
						rcnt_ff <= 3'h0;
						rst_ff  <= rline_ff ? S_IDLE : S_DATA;                      // glitch rejected
					end
				end
				S_DATA: begin
					if (rdone) begin
						rsh_ff <= {rline_ff, rsh_ff[7:1]};
						if (rcnt_ff == last_bit) begin
							rcnt_ff <= 3'h0;
							rst_ff  <= pen ? S_PAR : S_STOP;
						end else begin
							rcnt_ff <= rcnt_ff + 3'h1;
						end
					end
				end
				S_PAR: begin
					if (rdone) begin
						perr_ff <= par_bad;
						rst_ff  <= S_STOP;
					end
				end
				S_STOP: begin
					if (stop_low) begin
						ferr_ff <= 1'b1;
					end
					if (rdone) begin
						if (two_stop && (rcnt_ff == 3'h0)) begin
							rcnt_ff <= 3'h1;
						end else begin
							rst_ff <= S_IDLE;
						end
					end
				end
				default: rst_ff <= S_IDLE;
			endcase
		end
	end
endmodule

/* bench/fbu_uart_properties.sv */
`timescale 1ns/1ps
`include "fbu_consts.vh"
module fbu_uart_chk (
	input wire logic        core_clk_i,
	input wire logic        sys_rst_i,
	input wire logic [4:0]  addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic        wr_i,
	input wire logic        rd_i,
	input wire logic [31:0] rdata_o,
	input wire logic [2:0]  tx_pin_o,
	input wire logic [2:0]  tx_oe_o,
	input wire logic        irq_o
);
	// ----------------------------------------
	// shadows of mask and pin mux writes
	// ----------------------------------------
	logic [4:0] msk_ff;
	logic [2:0] oex_ff;
	logic       pm_wr;
	assign pm_wr = wr_i && (addr_i == `FBU_OFS_PMUX);
	// capture what software last wrote
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			msk_ff <= 5'h00;
			oex_ff <= 3'h0;
		end else begin
			if (wr_i && (addr_i == `FBU_OFS_IMSK))
				msk_ff <= wdata_i[4:0];
			if (pm_wr)
				oex_ff <= {wdata_i[20:18] == 3'h3, wdata_i[17:15] == 3'h3, wdata_i[14:12] == 3'h3};
		end
	end
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (sys_rst_i);
	a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
		else $error("read data not zero outside a read");
	a_unmapped_read: assert property (rd_i && (addr_i > 5'h18) |=> rdata_o == 32'h0)
		else $error("unmapped read not zero");
	a_stat_fields: assert property (rd_i && (addr_i == `FBU_OFS_STAT)
		|=> rdata_o[31:9] == 23'h0 && rdata_o[2:0] <= 3'h4 && rdata_o[5:3] <= 3'h4)
		else $error("status count out of range");
	a_ist_width: assert property (rd_i && (addr_i == `FBU_OFS_IST) |=> rdata_o[31:5] == 27'h0)
		else $error("interrupt status upper bits set");
	a_ctrl_readback: assert property ((wr_i && (addr_i == `FBU_OFS_CTRL)) ##2 (rd_i && (addr_i == `FBU_OFS_CTRL))
		|=> rdata_o == {25'h0, $past(wdata_i[6:0], 3)})
		else $error("control readback differs");
	a_oe_mux: assert property ($past(pm_wr, 2) |-> tx_oe_o == oex_ff)
		else $error("transmit enable does not follow mux");
	a_tx_idle_high: assert property (tx_oe_o == 3'h0 && $stable(tx_oe_o) |-> tx_pin_o == 3'h7)
		else $error("unselected transmit pin not high");
	a_start_len: assert property ($fell(tx_pin_o[0]) |-> !tx_pin_o[0] [*8])
		else $error("start bit too short");
	a_irq_masked: assert property (msk_ff == 5'h00 && $past(msk_ff) == 5'h00 |-> !irq_o)
		else $error("interrupt while all masked");
	// main scenarios
	c_tx_frame: cover property ($fell(tx_pin_o[0]));
	c_irq: cover property ($rose(irq_o));
	c_stat: cover property (rd_i && (addr_i == `FBU_OFS_STAT));
endmodule

/* bench/fbu_peer.sv */
`timescale 1ns/1ps
module fbu_peer #(
	parameter int BIT = 40,
	parameter int NB  = 11
) (
	input  wire logic        clk_i,
	output logic             line_o,
	input  wire logic        line_i,
	input  wire logic        send_i,
	input  wire logic [11:0] frame_i,
	output logic      [11:0] cap_o,
	output logic      [7:0]  got_o
);
	logic [11:0] sh;
	logic [11:0] rsh;
	int          i;
	int          j;
	// send a frame lsb first, each bit BIT cycles, idle high after
	initial begin
		line_o = 1'b1;
		forever begin
			@(posedge clk_i);
			if (send_i) begin
				sh = frame_i;
				for (i = 0; i < NB; i++) begin
					line_o <= sh[i];
					repeat (BIT) @(posedge clk_i);
				end
				line_o <= 1'b1;
			end
		end
	end
	// receive: on a low line, sample every bit at its middle
	initial begin
		got_o = 8'h00;
		cap_o = 12'h000;
		forever begin
			@(posedge clk_i);
			if (line_i === 1'b0) begin
				rsh = 12'h000;
				repeat (BIT / 2) @(posedge clk_i);
				for (j = 0; j < NB; j++) begin
					rsh[j] = line_i;
					if (j < NB - 1)
						repeat (BIT) @(posedge clk_i);
				end
				cap_o = rsh;
				got_o = got_o + 8'h01;
			end
		end
	end
endmodule

/* bench/tb.sv */
`timescale 1ns/1ps
`include "fbu_consts.vh"
module tb;
	localparam int          BIT = 40;
	localparam int          NB  = 11;
	localparam logic [31:0] ALL = 32'hFFFFFFFF;
	logic        core_clk_i;
	logic        sys_rst_i;
	logic        wr_i;
	logic        rd_i;
	logic        send;
	logic        irq_o;
	logic        peer_line;
	logic        p;
	logic [4:0]  addr_i;
	logic [31:0] wdata_i;
	logic [31:0] rdata_o;
	logic [2:0]  tx_pin_o;
	logic [2:0]  tx_oe_o;
	logic [11:0] frame;
	logic [11:0] cap;
	logic [7:0]  got;
	int          num_errors;
	int          check_count;
	int          m;
	int          len;
	fbu_uart #(.DEPTH(4)) dut (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .rx_pin_i({3'h7, peer_line}),
		.tx_pin_o(tx_pin_o), .tx_oe_o(tx_oe_o), .irq_o(irq_o));
	fbu_peer #(.BIT(BIT), .NB(NB)) peer (.clk_i(core_clk_i), .line_o(peer_line), .line_i(tx_pin_o[0]),
		.send_i(send), .frame_i(frame), .cap_o(cap), .got_o(got));
	// 50 MHz clock
	initial begin
		core_clk_i = 1'b0;
		forever #10 core_clk_i = ~core_clk_i;
	end
	// compare and count
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		@(posedge core_clk_i);
		addr_i  <= a;
		wdata_i <= d;
		wr_i    <= 1'b1;
		@(posedge core_clk_i);
		wr_i <= 1'b0;
	endtask
	task automatic rdchk(input string n, input logic [4:0] a, input logic [31:0] e, input logic [31:0] k);
		@(posedge core_clk_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge core_clk_i);
		rd_i <= 1'b0;
		#1;
		chk(n, e, rdata_o & k);
	endtask
	// wait for the peer to capture a frame, then let the last stop bit end
	task automatic tx_chk(input logic [11:0] e);
		logic [7:0] g0;
		int         k;
		g0 = got;
		for (k = 0; k < 2000 && got === g0; k++)
			@(posedge core_clk_i);
		if (got === g0) begin
			num_errors++;
			end_of_test();
		end
		chk("tx frame", {20'h0, e}, {20'h0, cap});
		repeat (BIT) @(posedge core_clk_i);
	endtask
	// cycles of the next low pulse on the first transmit pin, 2000 at most
	task automatic low_len(output int n);
		int k;
		n = 0;
		for (k = 0; k < 2000 && tx_pin_o[0] !== 1'b0; k++) begin
			@(posedge core_clk_i);
			#1;
		end
		for (k = 0; k < 2000 && tx_pin_o[0] === 1'b0; k++) begin
			@(posedge core_clk_i);
			#1;
			n++;
		end
	endtask
	task automatic rx_send(input logic [11:0] f);
		@(posedge core_clk_i);
		frame <= f;
		send  <= 1'b1;
		@(posedge core_clk_i);
		send <= 1'b0;
		repeat (NB * BIT + 20) @(posedge core_clk_i);
	endtask
	function automatic logic [11:0] mk7(input logic [6:0] d, input logic par);
		return {1'b0, 2'h3, par, d, 1'b0};
	endfunction
	task automatic end_of_test();
		if (num_errors == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		sys_rst_i   = 1'b1;
		wr_i        = 1'b0;
		rd_i        = 1'b0;
		addr_i      = 5'h00;
		wdata_i     = 32'h0;
		send        = 1'b0;
		frame       = 12'hFFF;
		num_errors  = 0;
		check_count = 0;
		repeat (10) @(posedge core_clk_i);
		sys_rst_i <= 1'b0;
		#1;
		chk("tx idle", 32'h7, {29'h0, tx_pin_o});
		chk("oe reset", 32'h0, {29'h0, tx_oe_o});
		rdchk("ctrl", `FBU_OFS_CTRL, 32'h0, ALL);
		rdchk("div", `FBU_OFS_DIV, 32'h80, ALL);
		rdchk("unmapped", 5'h1C, 32'h0, ALL);
		wr(`FBU_OFS_PMUX, 32'h3003);
		wr(`FBU_OFS_DIV, 32'h40);
		rdchk("div rb", `FBU_OFS_DIV, 32'h40, ALL);
		chk("oe", 32'h1, {29'h0, tx_oe_o});
		// start bit length: divider clamp, a fraction, then unit clocks of 5, 2.5 and 1.25 MHz
		for (m = 1; m < 6; m++) begin
			wr(`FBU_OFS_DIV, (m == 1) ? 32'h10 : (m == 2) ? 32'h44 : 32'h40);
			wr(`FBU_OFS_CTRL, (m < 3) ? 0 : m - 2);
			wr(`FBU_OFS_DATA, 32'hFF);
			low_len(len);
			chk("start len", (m == 1) ? 32'd40 : (m == 2) ? 32'd45 : (32'd40 << (m - 2)), len);
			repeat (10 * len) @(posedge core_clk_i);
		end
		// every parity type on an eight bit, one stop frame
		for (m = 0; m < 4; m++) begin
			p = (m == 0) ? ~^8'h45 : (m == 1) ? ^8'h45 : (m == 2);
			wr(`FBU_OFS_CTRL, 32'h08 | (m << 4));
			wr(`FBU_OFS_DATA, 32'h45);
			tx_chk({1'b0, 1'b1, p, 8'h45, 1'b0});
		end
		// seven bits, odd parity, two stops, two frames back to back
		wr(`FBU_OFS_CTRL, 32'h4C);
		rdchk("ctrl rb", `FBU_OFS_CTRL, 32'h4C, ALL);
		wr(`FBU_OFS_DATA, 32'h45);
		wr(`FBU_OFS_DATA, 32'hBA);
		tx_chk(mk7(7'h45, ~^7'h45));
		tx_chk(mk7(7'h3A, ~^7'h3A));
		// receive a good frame with the char interrupt enabled
		wr(`FBU_OFS_IST, 32'h1F);
		wr(`FBU_OFS_IMSK, 32'h08);
		rx_send(mk7(7'h45, ~^7'h45));
		rdchk("stat", `FBU_OFS_STAT, 32'h1, 32'h1FF);
		rdchk("ist", `FBU_OFS_IST, 32'h08, ALL);
		chk("irq", 32'h1, {31'h0, irq_o});
		rdchk("rx data", `FBU_OFS_DATA, 32'h45, ALL);
		wr(`FBU_OFS_IST, 32'h08);
		rdchk("ist clr", `FBU_OFS_IST, 32'h0, ALL);
		chk("irq clr", 32'h0, {31'h0, irq_o});
		// parity error, then a low first stop bit
		rx_send(mk7(7'h45, ^7'h45));
		rdchk("parity err", `FBU_OFS_IST, 32'h1, 32'h1);
		rx_send(mk7(7'h45, ~^7'h45) & 12'hDFF);
		rdchk("stop err", `FBU_OFS_IST, 32'h2, 32'h2);
		// mask all, drain, then overrun with five chars
		wr(`FBU_OFS_IMSK, 32'h0);
		for (m = 0; m < 4; m++)
			rdchk("drain", `FBU_OFS_DATA, (m < 2) ? 32'h45 : 32'h0, ALL);
		wr(`FBU_OFS_IST, 32'h1F);
		for (m = 0; m < 5; m++)
			rx_send(mk7(7'h40 + m[6:0], ~^(7'h40 + m[6:0])));
		rdchk("rx count", `FBU_OFS_STAT, 32'h4, 32'h7);
		rdchk("overrun", `FBU_OFS_IST, 32'h4, 32'h4);
		chk("irq masked", 32'h0, {31'h0, irq_o});
		for (m = 0; m < 4; m++)
			rdchk("fifo order", `FBU_OFS_DATA, 32'h40 + m, ALL);
		rdchk("empty", `FBU_OFS_DATA, 32'h0, ALL);
		// eight bits, space parity, one stop: a set parity bit is an error
		wr(`FBU_OFS_CTRL, 32'h38);
		rx_send({1'b0, 1'b1, 1'b0, 8'hC5, 1'b0});
		rdchk("rx 8 bit", `FBU_OFS_DATA, 32'hC5, ALL);
		rdchk("space ok", `FBU_OFS_IST, 32'h0, 32'h1);
		rx_send({1'b0, 1'b1, 1'b1, 8'hC5, 1'b0});
		rdchk("space err", `FBU_OFS_IST, 32'h1, 32'h1);
		end_of_test();
	end
endmodule
bind fbu_uart fbu_uart_chk u_chk (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
	.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .tx_pin_o(tx_pin_o),
	.tx_oe_o(tx_oe_o), .irq_o(irq_o));
